// ===== ulfmc_line_control.sv
// Module: per-channel handshake, pause/resume, driver enable, multidrop and wake
`timescale 1ns/10ps
// Behaviour
// [R01] Pacing 001 with pin mode 010 makes line 3 ready-out, line 2 ready-in.
// [R02] Alternate-pin handshake behaves exactly like the main handshake pair.
// [R03] Drop ready when receive FIFO full; hold transmitter while remote not ready.
// [R04] Pacing 010 compares each received character with pause and resume.
// [R05] Pause character stops transmit after the current character completes.
// [R06] Resume character restarts transmission while paused.
// [R07] Auto RS-485 asserts driver enable before sending any data.
// [R08] Zero delay drops driver enable right after the last stop bit.
// [R09] Nonzero delay holds driver enable 1 to 15 bit times longer.
// [R10] Pin mode bit 3 inverts driver enable polarity.
// [R11] Pacing 3 and 4 enable multidrop; resume=unicast, pause=multicast.
// [R12] Ninth or parity bit set marks address; matches either address register.
// [R13] Matching address byte not stored; following data bytes are stored.
// [R14] A non-matching address byte disables the receiver.
// [R15] Pacing 3 keeps the transmitter enabled always.
// [R16] Pacing 4 enables the transmitter only during an address match.
// [R17] Half-duplex bit ignores receive activity while transmitting.
// [R18] Enter suspend after 3 ms without any bus activity.
// [R19] Falling edge on wake pin while suspended requests remote wakeup.
// [R20] Host sets wake pin as input and advertises wakeup support.
// [R21] Wakeup support reported in bit 5 of the attributes byte.
// [R22] Turnaround delay counted in transmit bit periods after the stop bit.
module ulfmc_line_control #(
  parameter int IDLE_CYCLES = ulfmc_pkg::ULFMC_IDLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] flow_control,
  input wire logic [3:0] pin_mode,
  input wire logic [3:0] turnaround_delay,
  input wire logic [7:0] resume_char,
  input wire logic [7:0] pause_char,
  input wire logic wake_enable,
  input wire logic rx_fifo_room,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_ninth,
  input wire logic rx_line,
  input wire logic tx_pending,
  input wire logic tx_busy,
  input wire logic tx_done,
  input wire logic tx_bit_tick,
  input wire logic general_line_2_in,
  input wire logic remote_ready_n,
  input wire logic bus_activity,
  input wire logic wake_request_pin,
  output logic general_line_3_out,
  output logic general_line_3_oe_n,
  output logic main_ready_out_n,
  output logic driver_enable_pin,
  output logic tx_start_allow,
  output logic rx_write,
  output logic [7:0] rx_write_data,
  output logic rx_line_gated,
  output logic suspended,
  output logic wake_request,
  output logic [7:0] config_attributes
);
  import ulfmc_pkg::*;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  logic hw_mode, alt_pins, sw_mode, md_mode, md_gate, rs485, hdx;
  assign hw_mode = flow_control[2:0] == ULFMC_FLOW_HW;
  assign alt_pins = pin_mode[2:0] == ULFMC_PINS_HW_ALT;
  assign sw_mode = flow_control[2:0] == ULFMC_FLOW_SW; // [R04]
  assign md_mode = (flow_control[2:0] == ULFMC_FLOW_MD_TXON) ||
                   (flow_control[2:0] == ULFMC_FLOW_MD_TXGATE); // [R11]
  assign md_gate = flow_control[2:0] == ULFMC_FLOW_MD_TXGATE;
  assign rs485 = pin_mode[2:0] == ULFMC_PINS_RS485;
  assign hdx = flow_control[ULFMC_HDX_BIT];
  logic de_pol;
  assign de_pol = pin_mode[ULFMC_POL_BIT]; // [R10]

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic paused_reg, paused_next;
  logic match_reg, match_next;
  logic rx_off_reg, rx_off_next;
  logic rdy_reg, rdy_next;
  logic allow_reg, allow_next;
  logic wr_reg, wr_next;
  logic [7:0] wd_reg, wd_next;
  logic gate_reg, gate_next;
  ulfmc_de_type de_reg, de_next;
  logic [3:0] dly_reg, dly_next;
  logic de_out_reg, de_out_next;
  logic [31:0] idle_reg, idle_next;
  logic susp_reg, susp_next;
  logic wake_d_reg, wake_d_next;
  logic wreq_reg, wreq_next;
  logic [7:0] attr_reg, attr_next;
  logic remote_rdy_n, rx_accept, is_addr, addr_hit, tx_active, de_ready;
  logic oe_n_reg, oe_n_next;

  assign remote_rdy_n = alt_pins ? general_line_2_in : remote_ready_n; // [R01] [R02]
  assign tx_active = tx_busy || de_reg != ULFMC_DE_IDLE;
  assign de_ready = de_reg != ULFMC_DE_IDLE && de_next != ULFMC_DE_IDLE; // [R07]
  assign rx_accept = rx_valid && !(hdx && tx_active); // [R17]
  assign is_addr = rx_ninth; // [R12]
  assign addr_hit = rx_data == resume_char || rx_data == pause_char; // [R12]

  always_comb begin
    paused_next = paused_reg;
    match_next = match_reg;
    rx_off_next = rx_off_reg;
    wr_next = 1'b0;
    wd_next = wd_reg;
    if (!sw_mode) begin
      paused_next = 1'b0;
    end else if (rx_accept && rx_data == pause_char) begin
      paused_next = 1'b1; // [R05]
    end else if (rx_accept && rx_data == resume_char) begin
      paused_next = 1'b0; // [R06]
    end
    if (!md_mode) begin
      match_next = 1'b0;
      rx_off_next = 1'b0;
      wr_next = rx_accept;
      wd_next = rx_data;
    end else if (rx_accept && is_addr) begin
      match_next = addr_hit;
      rx_off_next = !addr_hit; // [R14]
    end else if (rx_accept && !rx_off_reg && match_reg) begin
      wr_next = 1'b1; // [R13]
      wd_next = rx_data;
    end
    rdy_next = (hw_mode && !rx_fifo_room); // [R03]
    // Starts only at character boundaries, so a pause lets the current one finish
    allow_next = !(hw_mode && remote_rdy_n) && !paused_next; // [R03] [R05]
    allow_next = allow_next && !(md_gate && !match_next); // [R15] [R16]
    allow_next = allow_next && !(rs485 && !de_ready); // [R07]
    gate_next = (hdx && tx_active) ? 1'b1 : rx_line; // [R17]
    oe_n_next = !(hw_mode && alt_pins); // [R01]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      paused_reg <= 1'b0;
      match_reg <= 1'b0;
      rx_off_reg <= 1'b0;
      rdy_reg <= 1'b0;
      allow_reg <= 1'b0;
      wr_reg <= 1'b0;
      wd_reg <= 8'h00;
      gate_reg <= 1'b1;
      oe_n_reg <= 1'b1;
    end else begin
      paused_reg <= paused_next;
      match_reg <= match_next;
      rx_off_reg <= rx_off_next;
      rdy_reg <= rdy_next;
      allow_reg <= allow_next;
      wr_reg <= wr_next;
      wd_reg <= wd_next;
      gate_reg <= gate_next;
      oe_n_reg <= oe_n_next;
    end
  end

  // ----------------------------------------
  // Driver enable
  // ----------------------------------------
  always_comb begin
    de_next = de_reg;
    dly_next = dly_reg;
    case (de_reg)
      ULFMC_DE_IDLE: begin
        if (rs485 && tx_pending) begin
          de_next = ULFMC_DE_ACTIVE; // [R07]
        end
      end
      ULFMC_DE_ACTIVE: begin
        if (tx_done && !tx_pending) begin
          if (turnaround_delay == ULFMC_DELAY_ZERO) begin
            de_next = ULFMC_DE_IDLE; // [R08]
          end else begin
            de_next = ULFMC_DE_HOLD; // [R09]
            dly_next = turnaround_delay;
          end
        end
      end
      ULFMC_DE_HOLD: begin
        if (tx_pending) begin
          de_next = ULFMC_DE_ACTIVE;
        end else if (tx_bit_tick) begin
          dly_next = dly_reg - 4'h1; // [R22]
          if (dly_reg == 4'h1) begin
            de_next = ULFMC_DE_IDLE;
          end
        end
      end
      default: de_next = ULFMC_DE_IDLE;
    endcase
    if (!rs485) begin
      de_next = ULFMC_DE_IDLE;
    end
    de_out_next = (de_next != ULFMC_DE_IDLE) ^ de_pol; // [R10]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      de_reg <= ULFMC_DE_IDLE;
      dly_reg <= 4'h0;
      de_out_reg <= 1'b0;
    end else begin
      de_reg <= de_next;
      dly_reg <= dly_next;
      de_out_reg <= de_out_next;
    end
  end

  // ----------------------------------------
  // Suspend and wake
  // ----------------------------------------
  always_comb begin
    idle_next = idle_reg;
    susp_next = susp_reg;
    if (bus_activity) begin
      idle_next = 32'h0;
      susp_next = 1'b0;
    end else if (idle_reg >= 32'(IDLE_CYCLES - 1)) begin
      susp_next = 1'b1; // [R18]
    end else begin
      idle_next = idle_reg + 32'h1;
    end
    wake_d_next = wake_request_pin;
    wreq_next = susp_reg && wake_d_reg && !wake_request_pin; // [R19]
    attr_next = ULFMC_ATTR_BASE;
    attr_next[ULFMC_WAKE_ATTR_BIT] = wake_enable; // [R21]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      idle_reg <= 32'h0;
      susp_reg <= 1'b0;
      wake_d_reg <= 1'b1;
      wreq_reg <= 1'b0;
      attr_reg <= 8'h00;
    end else begin
      idle_reg <= idle_next;
      susp_reg <= susp_next;
      wake_d_reg <= wake_d_next;
      wreq_reg <= wreq_next;
      attr_reg <= attr_next;
    end
  end

  assign general_line_3_out = rdy_reg;
  assign general_line_3_oe_n = oe_n_reg;
  assign main_ready_out_n = rdy_reg;
  assign driver_enable_pin = de_out_reg;
  assign tx_start_allow = allow_reg;
  assign rx_write = wr_reg;
  assign rx_write_data = wd_reg;
  assign rx_line_gated = gate_reg;
  assign suspended = susp_reg;
  assign wake_request = wreq_reg;
  assign config_attributes = attr_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_pause;
    @(posedge clk) disable iff (rst)
      sw_mode && rx_accept && rx_data == pause_char |=> !tx_start_allow;
  endproperty
  a_pause: assert property (p_pause) else $error("pause not honoured"); // [R05]
  property p_gate4;
    @(posedge clk) disable iff (rst)
      md_gate && $past(md_gate) && !match_reg |-> !tx_start_allow;
  endproperty
  a_gate4: assert property (p_gate4) else $error("mode 4 tx without match"); // [R16]
  property p_addr_drop;
    @(posedge clk) disable iff (rst) md_mode && rx_accept && is_addr |=> !rx_write;
  endproperty
  a_addr_drop: assert property (p_addr_drop) else $error("address byte stored"); // [R13]
  property p_nomatch;
    @(posedge clk) disable iff (rst)
      md_mode && rx_accept && is_addr && !addr_hit |=> rx_off_reg;
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("receiver not disabled"); // [R14]
  property p_de_on;
    @(posedge clk) disable iff (rst)
      rs485 && de_reg == ULFMC_DE_IDLE && tx_pending
        |=> ##1 driver_enable_pin != de_pol;
  endproperty
  a_de_on: assert property (p_de_on) else $error("driver enable late"); // [R07]
  property p_de_off0;
    @(posedge clk) disable iff (rst)
      rs485 && de_reg == ULFMC_DE_ACTIVE && tx_done && !tx_pending
        && turnaround_delay == 4'h0 |=> de_reg == ULFMC_DE_IDLE;
  endproperty
  a_de_off0: assert property (p_de_off0) else $error("driver enable held"); // [R08]
  property p_hdx;
    @(posedge clk) disable iff (rst) hdx && tx_busy |=> rx_line_gated;
  endproperty
  a_hdx: assert property (p_hdx) else $error("rx not ignored"); // [R17]
  property p_wake;
    @(posedge clk) disable iff (rst)
      suspended && $fell(wake_request_pin) |=> wake_request;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake request"); // [R19]
  property p_de_lead;
    @(posedge clk) disable iff (rst)
      rs485 && $past(rs485) && tx_start_allow |-> de_reg != ULFMC_DE_IDLE;
  endproperty
  a_de_lead: assert property (p_de_lead) else $error("start before driver enable"); // [R07]
  sequence s_hold_start;
    rs485 && de_reg == ULFMC_DE_ACTIVE && tx_done && !tx_pending
      && turnaround_delay != ULFMC_DELAY_ZERO;
  endsequence
  sequence s_hold_tick;
    rs485 && de_reg == ULFMC_DE_HOLD && !tx_pending && tx_bit_tick;
  endsequence
  property p_de_hold;
    @(posedge clk) disable iff (rst)
      s_hold_start |=> de_reg == ULFMC_DE_HOLD && dly_reg == $past(turnaround_delay);
  endproperty
  a_de_hold: assert property (p_de_hold) else $error("turnaround not started"); // [R09]
  property p_de_count;
    @(posedge clk) disable iff (rst)
      s_hold_tick ##0 dly_reg != 4'h1 |=> de_reg == ULFMC_DE_HOLD
        && dly_reg == $past(dly_reg) - 4'h1;
  endproperty
  a_de_count: assert property (p_de_count) else $error("turnaround miscounted"); // [R22]
  property p_de_last;
    @(posedge clk) disable iff (rst)
      s_hold_tick ##0 dly_reg == 4'h1 |=> de_reg == ULFMC_DE_IDLE;
  endproperty
  a_de_last: assert property (p_de_last) else $error("driver enable overstays"); // [R09]
  property p_de_pol;
    @(posedge clk) disable iff (rst)
      !$past(rst) |-> driver_enable_pin ==
        ((de_reg != ULFMC_DE_IDLE) ^ $past(de_pol));
  endproperty
  a_de_pol: assert property (p_de_pol) else $error("driver enable polarity"); // [R10]
  property p_ready;
    @(posedge clk) disable iff (rst)
      hw_mode |=> main_ready_out_n == !$past(rx_fifo_room)
        && general_line_3_out == main_ready_out_n;
  endproperty
  a_ready: assert property (p_ready) else $error("ready output wrong"); // [R03]
  property p_hw_hold;
    @(posedge clk) disable iff (rst) hw_mode && remote_rdy_n |=> !tx_start_allow;
  endproperty
  a_hw_hold: assert property (p_hw_hold) else $error("start while remote busy"); // [R02]
  property p_md_store;
    @(posedge clk) disable iff (rst)
      md_mode && rx_accept && !is_addr && match_reg && !rx_off_reg
        |=> rx_write && rx_write_data == $past(rx_data);
  endproperty
  a_md_store: assert property (p_md_store) else $error("data after match lost"); // [R13]
endmodule : ulfmc_line_control

// ===== ulfmc_pkg.sv
// Package: constants for the line, flow and multidrop control block
package ulfmc_pkg;
  localparam logic [2:0] ULFMC_FLOW_NONE = 3'h0;
  localparam logic [2:0] ULFMC_FLOW_HW = 3'h1;
  localparam logic [2:0] ULFMC_FLOW_SW = 3'h2;
  localparam logic [2:0] ULFMC_FLOW_MD_TXON = 3'h3;
  localparam logic [2:0] ULFMC_FLOW_MD_TXGATE = 3'h4;
  localparam logic [2:0] ULFMC_PINS_HW_ALT = 3'h2;
  localparam logic [2:0] ULFMC_PINS_RS485 = 3'h3;
  localparam int ULFMC_POL_BIT = 3;
  localparam int ULFMC_HDX_BIT = 3;
  localparam int ULFMC_WAKE_ATTR_BIT = 5;
  localparam int ULFMC_CLK_HZ = 20000000;
  localparam int ULFMC_IDLE_MS = 3;
  localparam int ULFMC_IDLE_CYCLES = ULFMC_CLK_HZ / 1000 * ULFMC_IDLE_MS;
  localparam logic [3:0] ULFMC_DELAY_ZERO = 4'h0;
  localparam logic [7:0] ULFMC_ATTR_BASE = 8'h80;
  typedef enum logic [1:0] {ULFMC_DE_IDLE, ULFMC_DE_ACTIVE, ULFMC_DE_HOLD} ulfmc_de_type;
endpackage : ulfmc_pkg

// ===== ulfmc_remote_node.sv
// Remote serial node model delivering received characters
`timescale 1ns/10ps
module ulfmc_remote_node (
  input wire logic clk,
  input wire logic go,
  input wire logic [8:0] go_word,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_ninth
);
  logic take_reg = 1'b0;
  logic [8:0] word_reg = 9'h000;
  always @(posedge clk) begin
    take_reg <= go;
    word_reg <= go_word;
  end
  // One strobe a character; ninth bit marks an address; idle shows inverse
  always @(negedge clk) begin
    rx_valid <= take_reg;
    rx_data <= take_reg ? word_reg[7:0] : ~word_reg[7:0];
    rx_ninth <= take_reg ? word_reg[8] : ~word_reg[8];
  end
endmodule : ulfmc_remote_node

// ===== uart_line_flow_multidrop_control_bench.sv
// Testbench for the line, flow and multidrop control block
`timescale 1ns/10ps
module uart_line_flow_multidrop_control_bench;
  import ulfmc_pkg::*;
  logic clk = 0, rst = 1, go = 0, wake_enable = 1, rx_fifo_room = 1, rx_line = 1;
  logic tx_pending = 0, tx_busy = 0, tx_done = 0, tx_bit_tick = 0, general_line_2_in = 0;
  logic remote_ready_n = 0, bus_activity = 1, wake_request_pin = 1;
  logic [3:0] flow_control = 4'h0, pin_mode = 4'h0, turnaround_delay = 4'h0;
  logic [7:0] resume_char = 8'h11, pause_char = 8'h13, rx_data, rx_write_data, config_attributes;
  logic [8:0] go_word = 9'h000;
  logic rx_valid, rx_ninth, general_line_3_out, general_line_3_oe_n, main_ready_out_n;
  logic driver_enable_pin, tx_start_allow, rx_write, rx_line_gated, suspended, wake_request;
  logic [7:0] last_wr = 8'h00;
  int fails = 0, n_checks = 0, wr_n = 0, wk_n = 0, cyc = 0;
  ulfmc_line_control #(.IDLE_CYCLES(20)) dut_u (.clk, .rst, .flow_control, .pin_mode,
    .turnaround_delay, .resume_char, .pause_char, .wake_enable, .rx_fifo_room, .rx_valid,
    .rx_data, .rx_ninth, .rx_line, .tx_pending, .tx_busy, .tx_done, .tx_bit_tick,
    .general_line_2_in, .remote_ready_n, .bus_activity, .wake_request_pin, .general_line_3_out,
    .general_line_3_oe_n, .main_ready_out_n, .driver_enable_pin, .tx_start_allow, .rx_write,
    .rx_write_data, .rx_line_gated, .suspended, .wake_request, .config_attributes);
  ulfmc_remote_node node_u (.clk(clk), .go(go), .go_word(go_word), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ninth(rx_ninth));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (rx_write === 1'b1) begin
      wr_n++;
      last_wr <= rx_write_data;
    end
    if (wake_request === 1'b1) wk_n++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task send(input logic [8:0] w);
    @(negedge clk);
    go = 1'b1;
    go_word = w;
    step(1);
    go = 1'b0;
    step(3);
  endtask : send
  task pulse_done;
    tx_done = 1'b1;
    step(1);
    tx_done = 1'b0;
  endtask : pulse_done
  task tick;
    tx_bit_tick = 1'b1;
    step(1);
    tx_bit_tick = 1'b0;
  endtask : tick
  task t_hw;
    flow_control = {1'b0, ULFMC_FLOW_HW};
    rx_fifo_room = 1'b0;
    remote_ready_n = 1'b1;
    step(3);
    chk("main_ready", main_ready_out_n, 8'h01);
    chk("allow", tx_start_allow, 8'h00);
    pin_mode = 4'h2;
    remote_ready_n = 1'b0;
    general_line_2_in = 1'b1;
    step(3);
    chk("line3_oe_n", general_line_3_oe_n, 8'h00);
    chk("line3", general_line_3_out, 8'h01);
    chk("allow", tx_start_allow, 8'h00);
    rx_fifo_room = 1'b1;
    general_line_2_in = 1'b0;
    step(3);
    chk("line3", general_line_3_out, 8'h00);
    chk("allow", tx_start_allow, 8'h01);
  endtask : t_hw
  task t_pause;
    flow_control = {1'b0, ULFMC_FLOW_SW};
    pin_mode = 4'h0;
    send(9'h013);
    chk("allow", tx_start_allow, 8'h00);
    send(9'h041);
    chk("allow", tx_start_allow, 8'h00);
    send(9'h011);
    chk("allow", tx_start_allow, 8'h01);
  endtask : t_pause
  task t_de;
    flow_control = {1'b0, ULFMC_FLOW_NONE};
    pin_mode = 4'h3;
    turnaround_delay = 4'h2;
    tx_pending = 1'b1;
    step(1);
    chk("de", driver_enable_pin, 8'h01);
    chk("allow", tx_start_allow, 8'h00);
    step(2);
    chk("allow", tx_start_allow, 8'h01);
    tx_busy = 1'b1;
    step(2);
    tx_pending = 1'b0;
    pulse_done();
    tx_busy = 1'b0;
    step(2);
    chk("de", driver_enable_pin, 8'h01);
    tick();
    step(2);
    chk("de", driver_enable_pin, 8'h01);
    tick();
    step(3);
    chk("de", driver_enable_pin, 8'h00);
    pin_mode = 4'hB;
    turnaround_delay = ULFMC_DELAY_ZERO;
    tx_pending = 1'b1;
    step(3);
    chk("de", driver_enable_pin, 8'h00);
    tx_pending = 1'b0;
    pulse_done();
    step(2);
    chk("de", driver_enable_pin, 8'h01);
  endtask : t_de
  task t_multi;
    int base;
    base = wr_n;
    pin_mode = 4'h0;
    resume_char = 8'h21;
    pause_char = 8'h7E;
    flow_control = {1'b0, ULFMC_FLOW_MD_TXGATE};
    send(9'h130);
    chk("allow", tx_start_allow, 8'h00);
    send(9'h055);
    chk("writes", 8'(wr_n - base), 8'h00);
    send(9'h17E);
    chk("writes", 8'(wr_n - base), 8'h00);
    chk("allow", tx_start_allow, 8'h01);
    send(9'h0A5);
    chk("wdata", last_wr, 8'hA5);
    flow_control = {1'b0, ULFMC_FLOW_MD_TXON};
    send(9'h130);
    chk("allow", tx_start_allow, 8'h01);
    send(9'h121);
    send(9'h0C3);
    chk("wdata", last_wr, 8'hC3);
    flow_control = 4'hB;
    tx_busy = 1'b1;
    rx_line = 1'b0;
    send(9'h05A);
    chk("gated", rx_line_gated, 8'h01);
    chk("writes", 8'(wr_n - base), 8'h02);
    tx_busy = 1'b0;
    rx_line = 1'b1;
  endtask : t_multi
  task t_sleep;
    bus_activity = 1'b0;
    step(15);
    chk("suspended", suspended, 8'h00);
    step(10);
    chk("suspended", suspended, 8'h01);
    wake_request_pin = 1'b0;
    step(3);
    chk("wakes", wk_n[7:0], 8'h01);
    wake_request_pin = 1'b1;
    bus_activity = 1'b1;
    step(3);
    chk("suspended", suspended, 8'h00);
  endtask : t_sleep
  initial begin
    step(2);
    rst = 1'b0;
    step(2);
    chk("attrs", config_attributes, 8'hA0);
    wake_enable = 1'b0;
    step(2);
    chk("attrs", config_attributes, ULFMC_ATTR_BASE);
    wake_enable = 1'b1;
    t_hw();
    t_pause();
    t_de();
    t_multi();
    t_sleep();
    give_verdict();
  end
endmodule : uart_line_flow_multidrop_control_bench
